// ==== core/safety_relay_supervisor.sv ====
// Supervisor of a dual-channel safety relay with delayable outputs
//
// Behaviour
// - Single channel: outputs on only while first channel closed, off when it opens.
// - Dual NO: both channels closed to enable; either opening drops outputs.
// - Dual NO: reset refused until both channels seen open after a trip.
// - Antivalent: NO closed and NC open to enable; change or short drops.
// - Antivalent: no re-enable until both inputs back in idle positions.
// - Zero-volt option acts like dual NO and drops on cross short.
// - Mat: both contacts made to enable; press or short drops and flashes.
// - Manual reset needs a close then open of the reset contact.
// - Reset closures shorter than the minimum time are ignored.
// - Linked autoreset activates outputs as soon as inputs are satisfied.
// - Contactor test contacts in the reset path must be closed to activate.
// - Four NO outputs, two delayable, plus one NC information output.
// - Inputs-satisfied indicator follows input conditions regardless of outputs.
// - Direct indicator only while both direct relays are on.
// - Delayed indicator only while both delayable relays are on.
// - Off-delay chosen by three strapped select links, sampled by the device.
// - Short range offers 0, 0.5, 1.0 and 1.5 s off-delays.
// - Long range offers 0, 1.0, 2.0 and 3.0 s off-delays.
// - Direct pair drops at once; delayable pair at once or after delay.
// - No reset while any output, or its running delay, is energized.
// - Power LED flashes on low supply and on mat actuation.
`timescale 1ns/10ps
module safety_relay_supervisor
    import relay_pkg::*;
#(
    parameter bit LONG_RANGE       = 1'b0,
    parameter int TICK_CYCLES      = relay_pkg::TICK_CYCLES,
    parameter int RESET_MIN_CYCLES = relay_pkg::RESET_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Configuration straps
    input  wire relay_pkg::input_option_t input_option,
    input  wire logic                     delay_select_link_a,
    input  wire logic                     delay_select_link_b,
    input  wire logic                     delay_select_link_c,
    // Safety inputs and supply monitor
    input  wire relay_pkg::channel_in_t   channels,
    input  wire logic                     supply_low,
    // Reset path, contactor test contacts in series
    input  wire logic                     reset_input,
    input  wire logic                     autoreset_link_input,
    // Relay outputs
    output relay_pkg::relay_out_t         relays,
    output logic                          info_nc_output,
    // Indicators
    output logic                          inputs_satisfied_indicator,
    output logic                          direct_outputs_indicator,
    output logic                          delayed_outputs_indicator,
    output logic                          power_led
);

    import relay_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int HOLD_W = $clog2(RESET_MIN_CYCLES + 1);
    localparam int BLNK_W = $clog2(FLASH_HALF_MS + 1);

    // Input conditions of each wiring option
    function automatic logic cond_met(input input_option_t opt, input channel_in_t ch);
        logic r;
        r = 1'b0;
        case (opt)
            OPT_SINGLE:     r = ch.first_channel_input;
            OPT_DUAL_NO:    r = ch.first_channel_input && ch.second_channel_input;
            OPT_ANTIVALENT: r = ch.first_channel_input && !ch.closed_idle_channel_input && !ch.short_detected;
            OPT_ZERO_VOLT:  r = ch.first_channel_input && ch.zero_volt_channel_input && !ch.short_detected;
            OPT_MAT:        r = ch.first_channel_input && ch.zero_volt_channel_input && !ch.short_detected;
            default:        r = 1'b0;
        endcase
        return r;
    endfunction : cond_met

    // Rest positions that must be seen before a new reset is accepted
    function automatic logic at_rest(input input_option_t opt, input channel_in_t ch);
        logic r;
        r = 1'b0;
        case (opt)
            OPT_SINGLE:     r = 1'b1;
            OPT_DUAL_NO:    r = !ch.first_channel_input && !ch.second_channel_input;
            OPT_ANTIVALENT: r = !ch.first_channel_input && ch.closed_idle_channel_input && !ch.short_detected;
            OPT_ZERO_VOLT:  r = !ch.first_channel_input && !ch.zero_volt_channel_input;
            OPT_MAT:        r = 1'b1;
            default:        r = 1'b0;
        endcase
        return r;
    endfunction : at_rest

    // Links to a four-way selection, first link found wins
    function automatic logic [1:0] link_decode(input logic a, input logic b, input logic c);
        logic [1:0] r;
        r = a ? 2'h1 : b ? 2'h2 : c ? 2'h3 : 2'h0;
        return r;
    endfunction : link_decode

    sup_state_t          state_r;
    sup_state_t          state_nxt;
    logic [TICK_W-1:0]   tick_cnt_r;
    logic [HOLD_W-1:0]   hold_cnt_r;
    logic [BLNK_W-1:0]   blink_cnt_r;
    logic                blink_r;
    logic [1:0]          delay_sel_r;
    logic                tick;
    logic                satisfied;
    logic                rest_ok;
    logic                hold_done;
    logic                auto_mode;
    logic                delay_zero;
    logic                start_delay;
    logic                timer_expired;
    logic                flash_req;
    logic [DELAY_W-1:0]  delay_ms;
    logic                direct_nxt;
    logic                delayed_nxt;
    logic                direct_r [2];
    logic                delayed_r [2];

    // Decoded conditions
    assign satisfied   = cond_met(input_option, channels);
    assign rest_ok     = at_rest(input_option, channels);
    assign auto_mode   = autoreset_link_input;
    assign hold_done   = hold_cnt_r >= HOLD_W'(RESET_MIN_CYCLES - 1);
    assign tick        = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);
    assign delay_ms    = LONG_RANGE ? LONG_DELAYS_MS[delay_sel_r]
                                    : SHORT_DELAYS_MS[delay_sel_r];
    assign delay_zero  = delay_ms == '0;
    assign start_delay = (state_r == ST_ON) && (state_nxt == ST_DELAY);
    assign flash_req   = supply_low || ((input_option == OPT_MAT) && !satisfied);

    // Millisecond tick divider
    always_ff @(posedge mclk) begin
        if (!rst_n || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    // Delay links sampled every cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            delay_sel_r <= 2'h0;
        end else begin
            delay_sel_r <= link_decode(delay_select_link_a, delay_select_link_b, delay_select_link_c);
        end
    end

    // Reset closure length, counted only while held closed
    always_ff @(posedge mclk) begin
        if (!rst_n || state_r != ST_HOLD) begin
            hold_cnt_r <= '0;
        end else if (!hold_done) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end

    // Supervisor sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (rest_ok) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (satisfied && reset_input && auto_mode) begin
                    state_nxt = ST_ON;
                end else if (satisfied && reset_input) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!satisfied) begin
                    state_nxt = ST_ARMED;
                end else if (!reset_input) begin
                    state_nxt = hold_done ? ST_ON : ST_ARMED;
                end
            end
            ST_ON: begin
                if (!satisfied) begin
                    state_nxt = delay_zero ? ST_IDLE : ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (timer_expired) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State register, power-up starts idle with outputs off
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Off-delay timer for the delayable pair
    off_delay_timer #(
        .W          (DELAY_W)
    ) u_delay (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .tick       (tick),
        .load       (start_delay),
        .load_value (delay_ms),
        .expired    (timer_expired)
    );

    // Relay drive follows the next state
    assign direct_nxt  = state_nxt == ST_ON;
    assign delayed_nxt = (state_nxt == ST_ON) || (state_nxt == ST_DELAY);

    // Both relays of each pair driven as two channels
    for (genvar i = 0; i < 2; i++) begin : g_pair
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                direct_r[i]  <= 1'b0;
                delayed_r[i] <= 1'b0;
            end else begin
                direct_r[i]  <= direct_nxt;
                delayed_r[i] <= delayed_nxt;
            end
        end
    end

    // Relay pairs gathered onto the output carrier
    assign relays.direct  = {direct_r[1], direct_r[0]};
    assign relays.delayed = {delayed_r[1], delayed_r[0]};

    // Information contact and input indicator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            info_nc_output             <= 1'b1;
            inputs_satisfied_indicator <= 1'b0;
        end else begin
            info_nc_output             <= !direct_nxt;
            inputs_satisfied_indicator <= satisfied;
        end
    end

    // Output indicators need both relays of a pair
    assign direct_outputs_indicator  = &relays.direct;
    assign delayed_outputs_indicator = &relays.delayed;

    // Flash generator for the power LED
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (tick && blink_cnt_r == BLNK_W'(FLASH_HALF_MS - 1)) begin
            blink_cnt_r <= '0;
            blink_r     <= !blink_r;
        end else if (tick) begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    // Power LED steady, or flashing on fault
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            power_led <= 1'b1;
        end else begin
            power_led <= flash_req ? blink_r : 1'b1;
        end
    end

    // Checks on the supervisor
    a_single_drop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (input_option == OPT_SINGLE && !channels.first_channel_input) |=> relays.direct == 2'h0)
        else $error("single channel open but direct relays on");

    a_dual_drop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (input_option == OPT_DUAL_NO && !(channels.first_channel_input && channels.second_channel_input))
        |=> relays.direct == 2'h0)
        else $error("dual channel incomplete but direct relays on");

    a_dual_rearm: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_r == ST_IDLE && input_option == OPT_DUAL_NO
         && (channels.first_channel_input || channels.second_channel_input)) |=> state_r == ST_IDLE)
        else $error("dual channel armed without both inputs open");

    a_antivalent_drop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (input_option == OPT_ANTIVALENT && (channels.short_detected || channels.closed_idle_channel_input))
        |=> relays.direct == 2'h0)
        else $error("antivalent fault but direct relays on");

    a_antivalent_rest: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_r == ST_IDLE && input_option == OPT_ANTIVALENT && !channels.closed_idle_channel_input)
        |=> state_r == ST_IDLE)
        else $error("antivalent armed outside rest position");

    a_zero_short: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (input_option == OPT_ZERO_VOLT && channels.short_detected) |=> relays.direct == 2'h0)
        else $error("zero volt short but direct relays on");

    a_mat_flash: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (input_option == OPT_MAT && !(channels.first_channel_input && channels.zero_volt_channel_input))
        |=> (relays.direct == 2'h0 && power_led == $past(blink_r)))
        else $error("mat pressed but direct relays on or power led steady");

    a_manual_release: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ($rose(relays.direct[0]) && !$past(auto_mode)) |-> (!$past(reset_input) && $past(reset_input, 2)))
        else $error("manual activation without reset close then open");

    a_min_closure: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ($rose(relays.direct[0]) && !$past(auto_mode)) |-> $past(hold_done))
        else $error("activation after too short reset closure");

    a_auto_start: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_r == ST_ARMED && auto_mode && satisfied && reset_input) |=> relays.direct == 2'h3)
        else $error("autoreset did not activate outputs");

    a_delay_refuse: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_r == ST_DELAY && !timer_expired)
        |=> (state_r != ST_ON && relays.direct == 2'h0 && relays.delayed == 2'h3))
        else $error("reset accepted while delayed relays still on");

    a_delay_drop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $fell(relays.direct[0])) |-> (relays.delayed[0] == !$past(delay_zero)))
        else $error("delayable pair did not follow selected delay");

endmodule : safety_relay_supervisor

// ==== core/relay_pkg.sv ====
// Shared constants, types and carriers of the safety relay supervisor
package relay_pkg;

    // Clock rate and derived cycle counts
    localparam int CLK_MHZ          = 250;
    localparam int TICK_US          = 1000;
    localparam int TICK_CYCLES      = TICK_US * CLK_MHZ;
    localparam int RESET_MIN_MS     = 100;
    localparam int RESET_MIN_CYCLES = RESET_MIN_MS * 1000 * CLK_MHZ;
    localparam int FLASH_HALF_MS    = 250;

    // Off-delay table in milliseconds, index is the decoded link selection
    localparam int DELAY_W = 12;
    localparam logic [3:0][DELAY_W-1:0] SHORT_DELAYS_MS = {12'h5DC, 12'h3E8, 12'h1F4, 12'h000};
    localparam logic [3:0][DELAY_W-1:0] LONG_DELAYS_MS  = {12'hBB8, 12'h7D0, 12'h3E8, 12'h000};

    // Input wiring options
    typedef enum logic [2:0] {
        OPT_SINGLE     = 3'h1,
        OPT_DUAL_NO    = 3'h2,
        OPT_ANTIVALENT = 3'h3,
        OPT_ZERO_VOLT  = 3'h4,
        OPT_MAT        = 3'h5
    } input_option_t;

    // Supervisor states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ARMED = 6'h02,
        ST_HOLD  = 6'h04,
        ST_ON    = 6'h08,
        ST_DELAY = 6'h10,
        ST_SPARE = 6'h20
    } sup_state_t;

    // Sensed safety inputs
    typedef struct packed {
        logic first_channel_input;
        logic second_channel_input;
        logic closed_idle_channel_input;
        logic zero_volt_channel_input;
        logic short_detected;
    } channel_in_t;

    // Relay drive pairs
    typedef struct packed {
        logic [1:0] direct;
        logic [1:0] delayed;
    } relay_out_t;

endpackage : relay_pkg

// ==== core/off_delay_timer.sv ====
// Millisecond down-counter for the delayable relay pair
`timescale 1ns/10ps
module off_delay_timer #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         tick,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    // Status
    output logic              expired
);

    logic [W-1:0] cnt_r;
    logic         run_r;

    // Expiry is seen once the loaded count has run down
    assign expired = run_r && (cnt_r == '0);

    // Load, count down on each tick, stop at expiry
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (load) begin
            cnt_r <= load_value;
            run_r <= 1'b1;
        end else if (expired) begin
            run_r <= 1'b0;
        end else if (run_r && tick) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

endmodule : off_delay_timer

// ==== tb/contact_field_model.sv ====
// Behavioural safety contacts, reset button and contactor feedback
`timescale 1ns/10ps
module contact_field_model
    import relay_pkg::*;
(
    // Commands from the bench
    input  wire logic              gate_closed,
    input  wire logic              one_open,
    input  wire logic              short_req,
    input  wire logic              press,
    input  wire logic              auto_link,
    input  wire logic              contactor_closed,
    // Lines into the supervisor
    output relay_pkg::channel_in_t channels,
    output logic                   reset_input
);
    // NO contacts close with the guard, NC opens, second may stay open alone
    assign channels.first_channel_input       = gate_closed;
    assign channels.second_channel_input      = gate_closed & ~one_open;
    assign channels.closed_idle_channel_input = ~gate_closed;
    assign channels.zero_volt_channel_input   = gate_closed;
    assign channels.short_detected            = short_req;
    // Contactor test contacts sit in series with the button or the autoreset link
    assign reset_input = contactor_closed & (press | auto_link);
endmodule : contact_field_model

// ==== tb/tb_safety_relay_supervisor.sv ====
// Self-checking bench of the safety relay supervisor
`timescale 1ns/10ps
module tb_safety_relay_supervisor;
    import relay_pkg::*;
    localparam int TK = 10;
    localparam int RM = 20;
    logic          mclk = 0, rst_n = 0, gate = 0, one_open = 0, short_req = 0, press = 0;
    logic          auto_link = 0, contactor = 1, supply_low = 0, exp_sat = 0;
    logic [2:0]    links = 3'b000;
    input_option_t opt = OPT_SINGLE;
    channel_in_t   ch;
    relay_out_t    relays, relays_long;
    logic          reset_in, info_nc, sat_ind, dir_ind, del_ind, power_led;
    int            err_count = 0, cmp_count = 0, cycles = 0, n, m, e, t0;
    int            delay_ms[4] = '{0, 500, 1000, 1500};
    int            delay_long_ms[4] = '{0, 1000, 2000, 3000};

    safety_relay_supervisor #(.LONG_RANGE(1'b0), .TICK_CYCLES(TK), .RESET_MIN_CYCLES(RM)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .input_option(opt),
        .delay_select_link_a(links[2]), .delay_select_link_b(links[1]), .delay_select_link_c(links[0]),
        .channels(ch), .supply_low(supply_low), .reset_input(reset_in),
        .autoreset_link_input(auto_link), .relays(relays), .info_nc_output(info_nc),
        .inputs_satisfied_indicator(sat_ind), .direct_outputs_indicator(dir_ind),
        .delayed_outputs_indicator(del_ind), .power_led(power_led));

    // Long-range variant on the same contacts, ticking twice as fast to keep the run short
    safety_relay_supervisor #(.LONG_RANGE(1'b1), .TICK_CYCLES(TK / 2), .RESET_MIN_CYCLES(RM)) u_dut_long (
        .mclk(mclk), .rst_n(rst_n), .input_option(opt),
        .delay_select_link_a(links[2]), .delay_select_link_b(links[1]), .delay_select_link_c(links[0]),
        .channels(ch), .supply_low(supply_low), .reset_input(reset_in),
        .autoreset_link_input(auto_link), .relays(relays_long), .info_nc_output(),
        .inputs_satisfied_indicator(), .direct_outputs_indicator(),
        .delayed_outputs_indicator(), .power_led());

    contact_field_model u_field (
        .gate_closed(gate), .one_open(one_open), .short_req(short_req), .press(press),
        .auto_link(auto_link), .contactor_closed(contactor), .channels(ch), .reset_input(reset_in));

    // Free-running clock
    always #2 mclk = ~mclk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Reference view of whether the configured input conditions hold
    function automatic logic sat_of(input input_option_t o, input channel_in_t c);
        case (o)
            OPT_SINGLE:     return c.first_channel_input;
            OPT_DUAL_NO:    return c.first_channel_input & c.second_channel_input;
            OPT_ANTIVALENT: return c.first_channel_input & ~c.closed_idle_channel_input & ~c.short_detected;
            OPT_ZERO_VOLT,
            OPT_MAT:        return c.first_channel_input & c.zero_volt_channel_input & ~c.short_detected;
            default:        return 1'b0;
        endcase
    endfunction : sat_of

    // Expected indicator trails the sampled contacts by one cycle; hang guard
    always @(posedge mclk) begin
        exp_sat <= rst_n ? sat_of(opt, ch) : 1'b0;
        cycles  <= cycles + 1;
        if (cycles > 80000) begin
            err_count++;
            final_report();
        end
    end

    // Indicators and pairing checked every cycle
    always @(negedge mclk) if (rst_n) begin
        check("inputs ind", exp_sat, sat_ind);
        check("direct ind", &relays.direct, dir_ind);
        check("delayed ind", &relays.delayed, del_ind);
        check("nc info", ~|relays.direct, info_nc);
        check("pairing", relays.direct[0], relays.direct[1]);
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : cyc

    // Hold the button, then release and look at the direct pair
    task automatic push(input int len, input logic on);
        press = 1;
        cyc(len);
        check("held", 2'b00, relays.direct);
        press = 0;
        cyc(3);
        check("released", on ? 2'b11 : 2'b00, relays.direct);
    endtask : push

    task automatic activate(input input_option_t o);
        opt  = o;
        gate = 0;
        cyc(4);
        gate = 1;
        cyc(3);
        push(10 + $urandom % 10, 0);
        push(RM + $urandom % 20, 1);
        check("all on", 4'hF, relays);
    endtask : activate

    task automatic blink(output int cnt);
        logic last;
        cnt  = 0;
        last = power_led;
        repeat (5200) begin
            cyc(1);
            if (power_led !== last) cnt++;
            last = power_led;
        end
    endtask : blink

    // Main sequence
    initial begin
        void'($urandom(37823));
        cyc(3);
        rst_n = 1;
        check("power-up", 4'h0, relays);
        check("led", 1'b1, power_led);
        gate = 1;
        cyc(5);
        check("no reset yet", 4'h0, relays);
        for (int o = 1; o <= 5; o++) begin
            activate(input_option_t'(o));
            gate = 0;
            cyc(2);
            check("trip", 4'h0, relays);
        end
        activate(OPT_SINGLE);
        rst_n = 0;
        cyc(1);
        check("mid reset", 4'h0, relays);
        rst_n = 1;
        cyc(5);
        check("after reset", 4'h0, relays);
        $display("test options done");
        activate(OPT_DUAL_NO);
        one_open = 1;
        cyc(2);
        check("one open", 2'b00, relays.direct);
        one_open = 0;
        cyc(2);
        push(RM + 5, 0);
        gate = 0;
        cyc(3);
        gate = 1;
        cyc(3);
        push(RM + 5, 1);
        gate = 0;
        cyc(3);
        for (int o = 3; o <= 5; o++) begin
            activate(input_option_t'(o));
            short_req = 1;
            cyc(2);
            check("short trip", 4'h0, relays);
            short_req = 0;
            cyc(2);
            if (o < 5) push(RM + 5, 0);
            gate = 0;
            cyc(3);
        end
        $display("test sequences done");
        activate(OPT_MAT);
        gate = 0;
        blink(n);
        check("mat flash", 1'b1, n >= 2);
        gate = 1;
        supply_low = 1;
        blink(n);
        check("low flash", 1'b1, n >= 2);
        supply_low = 0;
        cyc(3);
        check("led steady", 1'b1, power_led);
        opt = OPT_SINGLE;
        gate = 0;
        contactor = 0;
        cyc(3);
        gate = 1;
        cyc(3);
        push(RM + 5, 0);
        auto_link = 1;
        cyc(3);
        check("auto blocked", 4'h0, relays);
        gate = 0;
        contactor = 1;
        cyc(3);
        gate = 1;
        cyc(2);
        check("auto on", 4'hF, relays);
        gate = 0;
        cyc(3);
        auto_link = 0;
        $display("test reset modes done");
        for (int k = 0; k < 4; k++) begin
            links = (k == 1) ? {1'b1, 2'($urandom)} : (k == 2) ? {2'b01, 1'($urandom)} :
                    (k == 3) ? 3'b001 : 3'b000;
            activate(OPT_SINGLE);
            gate = 0;
            t0 = cycles;
            cyc(2);
            check("direct drop", 2'b00, relays.direct);
            if (k == 3) begin
                gate = 1;
                push(RM + 5, 0);
                gate = 0;
            end
            n = -1;
            m = -1;
            // Record the cycle at which each delayable pair first reads off
            while ((n < 0 || m < 0) && cycles - t0 < 20000) begin
                if (n < 0 && relays.delayed !== 2'b11) n = cycles - t0;
                if (m < 0 && relays_long.delayed !== 2'b11) m = cycles - t0;
                cyc(1);
            end
            e = delay_ms[k] * TK;
            check("delay", 1'b1, n >= e - TK && n <= e + TK + 4);
            e = delay_long_ms[k] * (TK / 2);
            check("long delay", 1'b1, m >= e - TK / 2 && m <= e + TK / 2 + 4);
            check("delayed off", 4'h0, relays);
            check("long off", 4'h0, relays_long);
        end
        $display("test delays done");
        final_report();
    end
endmodule : tb_safety_relay_supervisor
